// file: pkg/epa_defs.svh
`ifndef EPA_DEFS_SVH
`define EPA_DEFS_SVH
// Summary of operation
// RL1 - Smaller priority value is more urgent and is serviced first.
// RL2 - All priorities writable except reset, hard fault and NMI-class fixed ones.
// RL3 - Configurable priorities hold zero until software writes another value.
// RL4 - Configurable range 0 to 15; fixed ones are negative and always win.
// RL5 - Equal priority ties go to the smallest exception number.
// RL6 - Strictly higher priority new exception preempts the running handler.
// RL7 - Equal priority never preempts, whatever the exception numbers.
// RL8 - Equal priority arrival that cannot preempt stays recorded as pending.
// RL9 - Priority splits into upper group field and lower subpriority field.
// RL10 - Preemption compares only the group field; equal group never preempts.
// RL11 - Within equal group, lower subpriority is served first.
// RL12 - Equal group and subpriority: lowest request number is chosen.
// RL13 - Return only when done, nothing eligible pending, not late-arriving.
// RL14 - Group split comes from writable grouping setting; reset puts all in group.

// Number of configurable sources, id width, priority width
`define EPA_NUM_SRC      16
`define EPA_ID_W         5
`define EPA_PRI_W        4
`define EPA_PRI_RST      4'h0
`define EPA_SPLIT_RST    3'h0
// Fixed ids: 0 reset, 1 NMI, 2 hard fault; sources start at 3
`define EPA_ID_RESET     5'h00
`define EPA_ID_NMI       5'h01
`define EPA_ID_HFAULT    5'h02
`define EPA_ID_BASE      5'h03
// Extended priority: 2 sign-like bits; fixed values are below all configurable
`define EPA_XPRI_W       6
`define EPA_XPRI_RESET   6'h00
`define EPA_XPRI_NMI     6'h01
`define EPA_XPRI_HFAULT  6'h02
`define EPA_XPRI_IDLE    6'h3F
`endif

// file: pkg/epa_pkg.sv
package epa_pkg;
  typedef logic [5:0] epa_xpri_t;
  typedef logic [4:0] epa_id_t;
  typedef enum logic [1:0] {EPA_IDLE, EPA_ACTIVE, EPA_DONE} epa_state_e;
endpackage

// file: src/epa_arbiter.sv
`timescale 1ns/1ps
`include "epa_defs.svh"
module epa_arbiter import epa_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        req_reset,
  input  wire logic        req_nmi,
  input  wire logic        req_hfault,
  input  wire logic [15:0] req_irq,
  input  wire logic        pri_wr,
  input  wire logic [3:0]  pri_wr_idx,
  input  wire logic [3:0]  pri_wr_val,
  input  wire logic        split_wr,
  input  wire logic [2:0]  split_wr_val,
  input  wire logic        entry_ack,
  input  wire logic        handler_done,
  input  wire logic        late_arrival,
  output logic             take_valid,
  output logic             preempt,
  output logic [4:0]       take_id,
  output logic [5:0]       active_pri,
  output logic [18:0]      pend_vec,
  output logic             return_ok
);

  // Assertions below share this clock and reset
  default clocking cb_sys @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // Pin input synchronisers (three stages, second and third agree)
  // ------------------------------------------------------------
  localparam int NS = 19;
  logic [NS-1:0] s1_r, s2_r, s3_r, s1_nxt, s2_nxt, s3_nxt;
  logic [NS-1:0] req_in;
  logic [NS-1:0] req_lvl;

  // Raw request vector, fixed sources in the low bits
  always_comb begin
    req_in = {req_irq, req_hfault, req_nmi, req_reset};
    s1_nxt = req_in;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    req_lvl = s2_r & s3_r;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  // ------------------------------------------------------------
  // Priority and grouping settings
  // ------------------------------------------------------------
  logic [3:0] pri_r   [`EPA_NUM_SRC];
  logic [3:0] pri_nxt [`EPA_NUM_SRC];
  logic [2:0] split_r, split_nxt;

  // Writes land only on configurable entries
  always_comb begin
    for (int i = 0; i < `EPA_NUM_SRC; i++) begin
      pri_nxt[i] = pri_r[i];
      if (pri_wr && pri_wr_idx == 4'(i)) begin
        pri_nxt[i] = pri_wr_val; // see RL2
      end
    end
    split_nxt = split_wr ? split_wr_val : split_r; // see RL14
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < `EPA_NUM_SRC; i++) begin
        pri_r[i] <= `EPA_PRI_RST; // see RL3
      end
      split_r <= `EPA_SPLIT_RST; // see RL14
    end else begin
      pri_r   <= pri_nxt;
      split_r <= split_nxt;
    end
  end

  // ------------------------------------------------------------
  // Pending state and arbitration
  // ------------------------------------------------------------
  logic [NS-1:0] pend_r, pend_nxt;
  epa_xpri_t     xpri [NS];
  epa_xpri_t     gpri [NS];
  epa_xpri_t     best_pri, best_grp;
  epa_id_t       best_id;
  logic          best_vld;
  logic [3:0]    gmask;

  // Group mask keeps the upper 4-split bits; split 0 keeps all four
  always_comb begin
    gmask = 4'hF << split_r; // see RL9
    xpri[0] = `EPA_XPRI_RESET;
    xpri[1] = `EPA_XPRI_NMI;
    xpri[2] = `EPA_XPRI_HFAULT;
    gpri[0] = `EPA_XPRI_RESET;
    gpri[1] = `EPA_XPRI_NMI;
    gpri[2] = `EPA_XPRI_HFAULT;
    for (int i = 0; i < `EPA_NUM_SRC; i++) begin
      xpri[i+3] = {2'h1, pri_r[i]}; // see RL4
      gpri[i+3] = {2'h1, pri_r[i] & gmask}; // see RL10
    end
  end

  // Winner: lowest full priority, then lowest number by scan order
  always_comb begin
    best_vld = 1'b0;
    best_pri = `EPA_XPRI_IDLE;
    best_grp = `EPA_XPRI_IDLE;
    best_id  = '0;
    for (int i = 0; i < NS; i++) begin
      if (pend_r[i] && (!best_vld || xpri[i] < best_pri)) begin // see RL1
        best_vld = 1'b1; // see RL11
        best_pri = xpri[i]; // see RL5
        best_grp = gpri[i]; // see RL12
        best_id  = 5'(i);
      end
    end
  end

  // ------------------------------------------------------------
  // Handler tracking and outputs
  // ------------------------------------------------------------
  epa_state_e    st_r, st_nxt;
  epa_xpri_t     act_r, act_nxt;
  epa_xpri_t     stk_r, stk_nxt;
  logic          take_nxt, pre_nxt, ret_nxt;
  epa_id_t       tid_nxt;
  logic          can_take;
  epa_xpri_t     ceil_pri;

  // Sticky pending; acknowledged entry clears its bit, a still-high request wins
  always_comb begin
    pend_nxt = pend_r | req_lvl; // see RL8
    if (entry_ack && take_valid && !req_lvl[take_id]) begin
      pend_nxt[take_id] = 1'b0;
    end
    // A completed handler no longer blocks; compare with the one beneath
    ceil_pri = (st_r == EPA_DONE) ? stk_r : act_r; // see RL13
    can_take = best_vld && (best_grp < ceil_pri); // see RL6 see RL7
    take_nxt = can_take;
    pre_nxt  = can_take && (st_r == EPA_ACTIVE);
    tid_nxt  = best_id;
    st_nxt   = st_r;
    act_nxt  = act_r;
    stk_nxt  = stk_r;
    ret_nxt  = 1'b0;
    unique case (st_r)
      EPA_IDLE: begin
        if (entry_ack && take_valid) begin
          st_nxt  = EPA_ACTIVE;
          stk_nxt = act_r;
          act_nxt = gpri[take_id];
        end
      end
      EPA_ACTIVE: begin
        if (entry_ack && take_valid) begin
          stk_nxt = act_r;
          act_nxt = gpri[take_id];
        end else if (handler_done) begin
          st_nxt = EPA_DONE;
        end
      end
      EPA_DONE: begin
        // Return only with nothing eligible pending and no late arrival
        if (!can_take && !late_arrival) begin // see RL13
          ret_nxt = 1'b1;
          st_nxt  = EPA_IDLE;
          act_nxt = `EPA_XPRI_IDLE;
          stk_nxt = `EPA_XPRI_IDLE;
        end else if (entry_ack && take_valid) begin
          st_nxt  = EPA_ACTIVE;
          act_nxt = gpri[take_id];
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_r     <= '0;
      st_r       <= EPA_IDLE;
      act_r      <= `EPA_XPRI_IDLE;
      stk_r      <= `EPA_XPRI_IDLE;
      take_valid <= 1'b0;
      preempt    <= 1'b0;
      take_id    <= '0;
      active_pri <= `EPA_XPRI_IDLE;
      pend_vec   <= '0;
      return_ok  <= 1'b0;
    end else begin
      pend_r     <= pend_nxt;
      st_r       <= st_nxt;
      act_r      <= act_nxt;
      stk_r      <= stk_nxt;
      take_valid <= take_nxt;
      preempt    <= pre_nxt;
      take_id    <= tid_nxt;
      active_pri <= act_nxt;
      pend_vec   <= pend_nxt;
      return_ok  <= ret_nxt;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  // Preemption needs a strictly higher group than the active one
  a_no_equal_preempt: assert property ( // see RL7
    preempt |-> $past(best_grp) < $past(act_r))
    else $error("preempt without strictly higher group");

  // Preemption is only reported while a handler runs
  a_preempt_active: assert property ( // see RL6
    preempt |-> $past(st_r) == EPA_ACTIVE)
    else $error("preempt outside an active handler");

  // Configurable priorities come out of reset at zero
  a_pri_reset_zero: assert property ( // see RL3
    $fell(rst) |-> pri_r[0] == 4'h0 && pri_r[15] == 4'h0)
    else $error("priority not zero after reset");

  // Reset request always outranks everything else
  a_fixed_wins: assert property ( // see RL4
    pend_r[0] |-> best_id == 5'h00)
    else $error("reset request not selected first");

  // Non-maskable request outranks every configurable source
  a_nmi_over_cfg: assert property ( // see RL4
    (pend_r[1] && !pend_r[0]) |-> best_id == 5'h01)
    else $error("fixed request lost to a configurable one");

  // Of two pending sources the lower value is chosen
  a_lowest_value: assert property ( // see RL1
    (best_vld && pend_r[3] && pend_r[4] && pri_r[0] < pri_r[1]
     && pend_r[2:0] == 3'h0) |-> best_id != 5'h04)
    else $error("higher value chosen over lower");

  // Equal values go to the smaller number
  a_tie_low_num: assert property ( // see RL5
    (pend_r[3] && pend_r[4] && pri_r[0] == pri_r[1])
    |-> best_id != 5'h04)
    else $error("tie not broken by lowest number");

  // Equal or lower group never raises a take while active
  a_equal_no_take: assert property ( // see RL10
    (st_r == EPA_ACTIVE && best_vld && best_grp >= act_r) |=> !take_valid)
    else $error("take raised without a higher group");

  // Pending bits only drop when an entry is acknowledged
  a_pend_sticky: assert property ( // see RL8
    (pend_r != 19'h0 && !(entry_ack && take_valid))
    |=> ($past(pend_r) & ~pend_r) == 19'h0)
    else $error("pending bit lost without an entry");

  // A request held four edges is pending by the next one
  sequence s_req_held;
    req_irq[0] [*4];
  endsequence
  a_req_sync: assert property ( // see RL8
    s_req_held |=> pend_r[3])
    else $error("held request never became pending");

  // Writes land in the addressed entry and the grouping setting
  a_pri_write: assert property ( // see RL2
    pri_wr |=> pri_r[$past(pri_wr_idx)] == $past(pri_wr_val))
    else $error("priority write did not land");

  a_split_write: assert property ( // see RL14
    split_wr |=> split_r == $past(split_wr_val))
    else $error("grouping write did not land");

  // Late arrival holds the return back
  sequence s_done;
    st_r == EPA_DONE && late_arrival;
  endsequence
  a_late_blocks_ret: assert property ( // see RL13
    s_done |=> !return_ok)
    else $error("return despite late arrival");

  // Return only from a completed handler with nothing eligible
  a_ret_from_done: assert property ( // see RL13
    return_ok |-> $past(st_r) == EPA_DONE && $past(!can_take))
    else $error("return without completed handler");

  // An eligible source beneath the completed handler blocks return
  a_done_ceiling: assert property ( // see RL13
    (st_r == EPA_DONE && best_vld && best_grp < stk_r) |=> !return_ok)
    else $error("return while an eligible source waits");

  // Return is a single-cycle pulse back to idle
  a_return_pulse: assert property ( // see RL13
    return_ok |-> (active_pri == `EPA_XPRI_IDLE) ##1 !return_ok)
    else $error("return not a single pulse to idle");

  // Grouping comes out of reset with every bit in the group field
  a_split_reset: assert property ( // see RL14
    $fell(rst) |-> split_r == 3'h0)
    else $error("grouping not all-group after reset");

endmodule

// file: test/epa_core_model.sv
`timescale 1ns/1ps
// --------------------------------------------------------------
// Core entry stand-in: acks the winner after a settable delay
// --------------------------------------------------------------
module epa_core_model #(
  parameter int ACK_DLY = 2
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic take_valid,
  input  wire logic ack_en,
  output logic      entry_ack
);
  int wait_cnt = 0;
  // One-cycle ack, never while take_valid is low
  always @(posedge sys_clk) begin
    entry_ack <= 1'b0;
    if (rst || !take_valid || !ack_en || entry_ack) begin
      wait_cnt <= 0;
    end else if (wait_cnt == ACK_DLY) begin
      entry_ack <= 1'b1; // Pulse, released at the next edge
      wait_cnt  <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench import epa_pkg::*; ;
  typedef struct packed {
    logic [2:0] fx;
    logic [3:0] ia, pa, ib, pb;
    logic [2:0] sp;
    logic [4:0] ex;
  } epa_row_s;
  logic sys_clk = 0, rst = 1, req_reset = 0, req_nmi = 0;
  logic req_hfault = 0, pri_wr = 0, split_wr = 0, ack_en = 0;
  logic handler_done = 0, late_arrival = 0, entry_ack;
  logic [15:0] req_irq = 0;
  logic [3:0]  pri_wr_idx = 0, pri_wr_val = 0;
  logic [2:0]  split_wr_val = 0;
  logic        take_valid, preempt, return_ok;
  logic [4:0]  take_id;
  logic [5:0]  active_pri;
  logic [18:0] pend_vec;
  int          num_errors = 0, check_count = 0;
  bit          hit;
  // Two requests each: fixed mask, src/pri pairs, split, winner id
  epa_row_s rows [8] = '{
    '{3'h0, 4'h2, 4'h5, 4'h7, 4'h3, 3'h0, 5'h0A},
    '{3'h0, 4'h0, 4'h3, 4'h1, 4'h5, 3'h0, 5'h03},
    '{3'h0, 4'h2, 4'h4, 4'h7, 4'h4, 3'h0, 5'h05},
    '{3'h0, 4'h9, 4'h0, 4'h4, 4'h0, 3'h0, 5'h07},
    '{3'h0, 4'hB, 4'h5, 4'h3, 4'h5, 3'h2, 5'h06},
    '{3'h0, 4'h1, 4'h6, 4'h6, 4'h5, 3'h2, 5'h09},
    '{3'h3, 4'h0, 4'h0, 4'h1, 4'h0, 3'h0, 5'h01},
    '{3'h5, 4'h0, 4'h0, 4'h1, 4'h0, 3'h0, 5'h00}
  };
  always #2 sys_clk = ~sys_clk;
  epa_arbiter u_dut (.sys_clk, .rst, .req_reset, .req_nmi, .req_hfault,
    .req_irq, .pri_wr, .pri_wr_idx, .pri_wr_val, .split_wr, .split_wr_val,
    .entry_ack, .handler_done, .late_arrival, .take_valid, .preempt,
    .take_id, .active_pri, .pend_vec, .return_ok);
  epa_core_model #(.ACK_DLY(2)) u_core (.sys_clk, .rst, .take_valid,
    .ack_en, .entry_ack);
  // ---------------------------------
  // Shared tasks
  // ---------------------------------
  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [18:0] g, e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rst_dut();
    rst = 1'b1;
    ack_en = 1'b0;
    req_irq = 16'h0;
    {req_reset, req_nmi, req_hfault} = 3'h0;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
  endtask
  // Pulse a priority write, or a split write when sp is set
  task automatic wr(input logic sp, input logic [3:0] i, v);
    pri_wr = !sp;
    split_wr = sp;
    pri_wr_idx = i;
    pri_wr_val = v;
    split_wr_val = v[2:0];
    @(negedge sys_clk);
    pri_wr = 1'b0;
    split_wr = 1'b0;
    @(negedge sys_clk);
  endtask
  // Bounded watch: 0 take_valid, 1 handler active, 2 return_ok
  task automatic watch(input int s, n);
    hit = 1'b0;
    repeat (n) begin
      @(negedge sys_clk);
      if ((s == 0 && take_valid === 1'b1) || (s == 1 &&
          active_pri !== 6'h3F) || (s == 2 && return_ok === 1'b1)) begin
        hit = 1'b1;
        return;
      end
    end
  endtask
  task automatic wait_for(input int s);
    watch(s, 20);
    if (!hit) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  // ---------------------------------
  // Main sequence
  // ---------------------------------
  initial begin
    foreach (rows[i]) begin
      rst_dut();
      if (rows[i].sp != 3'h0) wr(1'b1, 4'h0, {1'b0, rows[i].sp});
      if (rows[i].pa != 4'h0) wr(1'b0, rows[i].ia, rows[i].pa);
      if (rows[i].pb != 4'h0) wr(1'b0, rows[i].ib, rows[i].pb);
      {req_reset, req_nmi, req_hfault} = rows[i].fx;
      req_irq = (16'h1 << rows[i].ia) | (16'h1 << rows[i].ib);
      wait_for(0);
      chk(19'(take_id), 19'(rows[i].ex));
      chk(pend_vec, (19'h1 << (rows[i].ia + 5'h3)) |
        (19'h1 << (rows[i].ib + 5'h3)) |
        {16'h0, rows[i].fx[0], rows[i].fx[1], rows[i].fx[2]});
    end
    // Values right after reset
    rst_dut();
    chk(19'(active_pri), 19'h3F);
    chk(19'({take_valid, preempt, return_ok}), 19'h0);
    chk(pend_vec, 19'h0);
    // Nesting with a split of two subpriority bits
    wr(1'b1, 4'h0, 4'h2);
    wr(1'b0, 4'h0, 4'h9);
    wr(1'b0, 4'h1, 4'h8);
    wr(1'b0, 4'h2, 4'h7);
    ack_en = 1'b1;
    req_irq = 16'h0001;
    wait_for(0);
    req_irq = 16'h0;
    wait_for(1);
    ack_en = 1'b0;
    req_irq = 16'h0002;
    watch(0, 12);
    chk(19'(hit), 19'h0);
    chk(pend_vec, 19'h10);
    req_irq = 16'h0006;
    wait_for(0);
    chk(19'(preempt), 19'h1);
    chk(19'(take_id), 19'h5);
    // Return: plain, late-arriving, and with an eligible pending one
    for (int k = 0; k < 3; k++) begin
      rst_dut();
      ack_en = 1'b1;
      late_arrival = (k == 1);
      req_irq = 16'h0020;
      wait_for(0);
      req_irq = (k == 2) ? 16'h0040 : 16'h0;
      wait_for(1);
      ack_en = 1'b0;
      handler_done = 1'b1;
      @(negedge sys_clk);
      handler_done = 1'b0;
      watch(2, 6);
      chk(19'(hit), 19'(k == 0));
    end
    tally_and_finish();
  end
endmodule
